// ### rtl/pdw_pkg.sv
package pdw_pkg;

   // Clock rates
   localparam int unsigned CLK_FREQ_HZ    = 40_000_000;
   localparam int unsigned LSRC_FREQ_HZ   = 10_000;
   localparam int unsigned LSRC_DIV       = CLK_FREQ_HZ / LSRC_FREQ_HZ;
   localparam int unsigned LSRC_W         = 16;

   // Counter and prescaler shape
   localparam int unsigned CNT_W          = 6;
   localparam int unsigned PRE_W          = 10;
   localparam int unsigned PS_W           = 3;
   localparam logic [CNT_W-1:0] CNT_LAST  = 6'h3F;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;

   // Bus shape
   localparam int unsigned ADDR_W         = 10;
   localparam int unsigned DATA_W         = 32;
   localparam int unsigned IDX_W          = 8;
   localparam int unsigned REG_W          = 8;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL     = 8'hAB;
   localparam logic [IDX_W-1:0] IDX_GIE      = 8'hA8;
   localparam logic [IDX_W-1:0] IDX_EIE      = 8'hBD;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'hB0;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 8'hB1;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 8'hB2;
   localparam logic [IDX_W-1:0] IDX_COUNT    = 8'hB3;

   // Control register fields
   localparam int unsigned CTRL_EN_BIT    = 7;
   localparam int unsigned CTRL_CLR_BIT   = 6;
   localparam int unsigned CTRL_FLAG_BIT  = 5;
   localparam int unsigned CTRL_PS_LSB    = 0;
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

   // Enable bits of the interrupt enable registers
   localparam int unsigned EIE_WAKE_BIT   = 1;
   localparam int unsigned GIE_BIT        = 7;

   // Sticky event bits
   localparam int unsigned IRQ_W          = 2;
   localparam int unsigned IRQ_TIMEOUT    = 0;
   localparam int unsigned IRQ_WAKE       = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

endpackage

// ### rtl/pdw_lsrc_tick.sv
`timescale 1ns/1ps

// Free-running stand-in for the low-speed RC oscillator
module pdw_lsrc_tick #(
   parameter int unsigned DIV = pdw_pkg::LSRC_DIV
) (
   input  wire logic clk,
   input  wire logic srst,
   output logic      tick
);

   localparam logic [pdw_pkg::LSRC_W-1:0] LAST =
      pdw_pkg::LSRC_W'(DIV - 1);

   logic [pdw_pkg::LSRC_W-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end

endmodule

// ### rtl/pdw_prescaler.sv
`timescale 1ns/1ps

module pdw_prescaler (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic                       clear,
   input  wire logic                       run,
   input  wire logic                       src_tick,
   input  wire logic [pdw_pkg::PS_W-1:0]   sel,
   output logic                            div_tick
);

   logic [pdw_pkg::PRE_W-1:0] cnt_q;

   // Last count of each ratio: 1,4,8,32,64,256,512,1024
   function automatic logic [pdw_pkg::PRE_W-1:0] last_of(
      input logic [pdw_pkg::PS_W-1:0] s);
      unique case (s)
         3'h0: last_of = 10'h000;
         3'h1: last_of = 10'h003;
         3'h2: last_of = 10'h007;
         3'h3: last_of = 10'h01F;
         3'h4: last_of = 10'h03F;
         3'h5: last_of = 10'h0FF;
         3'h6: last_of = 10'h1FF;
         3'h7: last_of = 10'h3FF;
      endcase
   endfunction

   always_ff @(posedge clk) begin
      if (srst || clear) begin
         cnt_q    <= '0;
         div_tick <= 1'b0;
      end else if (run && src_tick) begin
         // Ratio change mid-count takes effect at once; a count already past the new last ends at the next tick
         if (cnt_q >= last_of(sel)) begin
            cnt_q    <= '0;
            div_tick <= 1'b1;
         end else begin
            cnt_q    <= cnt_q + 1'b1;
            div_tick <= 1'b0;
         end
      end else begin
         div_tick <= 1'b0;
      end
   end

endmodule

// ### rtl/pdw_timer.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps

module pdw_timer #(
   parameter int unsigned LSRC_DIV = pdw_pkg::LSRC_DIV
) (
   input  wire logic                          CLOCK,
   input  wire logic                          SRST,
   input  wire logic [pdw_pkg::ADDR_W-1:0]    AWADDR,
   input  wire logic [2:0]                    AWPROT,
   input  wire logic                          AWVALID,
   output logic                               AWREADY,
   input  wire logic [pdw_pkg::DATA_W-1:0]    WDATA,
   input  wire logic [3:0]                    WSTRB,
   input  wire logic                          WVALID,
   output logic                               WREADY,
   output logic [1:0]                         BRESP,
   output logic                               BVALID,
   input  wire logic                          BREADY,
   input  wire logic [pdw_pkg::ADDR_W-1:0]    ARADDR,
   input  wire logic [2:0]                    ARPROT,
   input  wire logic                          ARVALID,
   output logic                               ARREADY,
   output logic [pdw_pkg::DATA_W-1:0]         RDATA,
   output logic [1:0]                         RRESP,
   output logic                               RVALID,
   input  wire logic                          RREADY,
   input  wire logic                          IDLE_MODE,
   input  wire logic                          POWER_DOWN_MODE,
   output logic                               IRQ,
   output logic                               WAKEUP
);

   // Write channel state
   logic                         aw_full_q;
   logic                         aw_full_d;
   logic [pdw_pkg::IDX_W-1:0]    aw_idx_q;
   logic                         w_full_q;
   logic                         w_full_d;
   logic [pdw_pkg::REG_W-1:0]    w_data_q;
   logic                         w_lane_q;
   logic                         wr_go;
   logic                         wr_byte;
   logic                         wr_ok;

   // Timer state
   logic                         timer_enable_q;
   logic [pdw_pkg::PS_W-1:0]     prescale_select_q;
   logic                         timeout_flag_q;
   logic [pdw_pkg::CNT_W-1:0]    wakeup_counter_q;
   logic                         wakeup_irq_enable_q;
   logic                         global_irq_enable_q;
   logic [pdw_pkg::IRQ_W-1:0]    irq_stat_q;
   logic [pdw_pkg::IRQ_W-1:0]    irq_en_q;
   logic                         count_clear;
   logic                         lsrc_tick;
   logic                         div_tick;
   logic                         timeout;
   logic                         asleep;
   logic [pdw_pkg::IRQ_W-1:0]    irq_set;

   // Read path
   logic [pdw_pkg::IDX_W-1:0]    rd_idx;
   logic [pdw_pkg::REG_W-1:0]    rd_val;
   logic                         rd_hit;

   // Register map membership, shared by read and write decode
   function automatic logic idx_mapped(
      input logic [pdw_pkg::IDX_W-1:0] idx);
      idx_mapped = (idx == pdw_pkg::IDX_CTRL)
                || (idx == pdw_pkg::IDX_GIE)
                || (idx == pdw_pkg::IDX_EIE)
                || (idx == pdw_pkg::IDX_IRQ_STAT)
                || (idx == pdw_pkg::IDX_IRQ_CLR)
                || (idx == pdw_pkg::IDX_IRQ_EN)
                || (idx == pdw_pkg::IDX_COUNT);
   endfunction

   function automatic logic [pdw_pkg::IDX_W-1:0] idx_of(
      input logic [pdw_pkg::ADDR_W-1:0] a);
      idx_of = a[pdw_pkg::ADDR_W-1:2];
   endfunction

   // AXI4-Lite write: address and data taken in either order
   always_comb begin
      wr_go     = aw_full_q && w_full_q && !BVALID;
      aw_full_d = aw_full_q || (AWVALID && AWREADY);
      w_full_d  = w_full_q || (WVALID && WREADY);
      if (wr_go) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         AWREADY   <= 1'b0;
         WREADY    <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         AWREADY   <= !aw_full_d;
         WREADY    <= !w_full_d;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         aw_idx_q <= '0;
         w_data_q <= '0;
         w_lane_q <= 1'b0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_idx_q <= idx_of(AWADDR);
         end
         if (WVALID && WREADY) begin
            w_data_q <= WDATA[pdw_pkg::REG_W-1:0];
            w_lane_q <= WSTRB[0];
         end
      end
   end

   // Only byte lane 0 holds register bits
   assign wr_ok   = idx_mapped(aw_idx_q);
   assign wr_byte = wr_go && wr_ok && w_lane_q;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         BVALID <= 1'b0;
         BRESP  <= pdw_pkg::RESP_OKAY;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         BRESP  <= wr_ok ? pdw_pkg::RESP_OKAY : pdw_pkg::RESP_SLVERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // Control register fields
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         timer_enable_q    <= pdw_pkg::CTRL_RESET[pdw_pkg::CTRL_EN_BIT];
         prescale_select_q <=
            pdw_pkg::CTRL_RESET[pdw_pkg::CTRL_PS_LSB +: pdw_pkg::PS_W];
      end else if (wr_byte && aw_idx_q == pdw_pkg::IDX_CTRL) begin
         timer_enable_q    <= w_data_q[pdw_pkg::CTRL_EN_BIT];
         prescale_select_q <=
            w_data_q[pdw_pkg::CTRL_PS_LSB +: pdw_pkg::PS_W];
      end
   end

   // Clear is a one-cycle strobe, never stored, so it reads back zero
   assign count_clear = wr_byte && (aw_idx_q == pdw_pkg::IDX_CTRL)
                     && w_data_q[pdw_pkg::CTRL_CLR_BIT];

   // Flag: hardware set wins over a software write in the same cycle
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         timeout_flag_q <= pdw_pkg::CTRL_RESET[pdw_pkg::CTRL_FLAG_BIT];
      end else if (timeout) begin
         timeout_flag_q <= 1'b1;
      end else if (wr_byte && aw_idx_q == pdw_pkg::IDX_CTRL) begin
         timeout_flag_q <= w_data_q[pdw_pkg::CTRL_FLAG_BIT];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         wakeup_irq_enable_q <= 1'b0;
         global_irq_enable_q <= 1'b0;
         irq_en_q            <= pdw_pkg::IRQ_RESET;
      end else if (wr_byte) begin
         if (aw_idx_q == pdw_pkg::IDX_EIE) begin
            wakeup_irq_enable_q <= w_data_q[pdw_pkg::EIE_WAKE_BIT];
         end
         if (aw_idx_q == pdw_pkg::IDX_GIE) begin
            global_irq_enable_q <= w_data_q[pdw_pkg::GIE_BIT];
         end
         if (aw_idx_q == pdw_pkg::IDX_IRQ_EN) begin
            irq_en_q <= w_data_q[pdw_pkg::IRQ_W-1:0];
         end
      end
   end

   // Low-speed source; LSRC_DIV may be shortened for simulation
   pdw_lsrc_tick #(
      .DIV      (LSRC_DIV)
   ) u_lsrc (
      .clk      (CLOCK),
      .srst     (SRST),
      .tick     (lsrc_tick)
   );

   pdw_prescaler u_pre (
      .clk      (CLOCK),
      .srst     (SRST),
      .clear    (count_clear),
      .run      (timer_enable_q),
      .src_tick (lsrc_tick),
      .sel      (prescale_select_q),
      .div_tick (div_tick)
   );

   // A disable between the tick and its use drops that tick
   assign timeout = timer_enable_q && div_tick && !count_clear
                 && (wakeup_counter_q == pdw_pkg::CNT_LAST);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         wakeup_counter_q <= pdw_pkg::CNT_ZERO;
      end else if (count_clear) begin
         wakeup_counter_q <= pdw_pkg::CNT_ZERO;
      end else if (timer_enable_q && div_tick) begin
         // Natural wrap from the last count back to zero
         wakeup_counter_q <= wakeup_counter_q + 1'b1;
      end
   end

   assign asleep = IDLE_MODE || POWER_DOWN_MODE;

   always_comb begin
      irq_set              = '0;
      irq_set[pdw_pkg::IRQ_TIMEOUT] = timeout;
      irq_set[pdw_pkg::IRQ_WAKE]    = timeout && asleep;
   end

   // Sticky events; a set in the clearing cycle survives
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         irq_stat_q <= pdw_pkg::IRQ_RESET;
      end else if (wr_byte && aw_idx_q == pdw_pkg::IDX_IRQ_CLR) begin
         irq_stat_q <= (irq_stat_q & ~w_data_q[pdw_pkg::IRQ_W-1:0])
                     | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= wakeup_irq_enable_q && global_irq_enable_q
             && |(irq_stat_q & irq_en_q);
      end
   end

   // Wake request is a pulse; the power controller holds its own state
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         WAKEUP <= 1'b0;
      end else begin
         WAKEUP <= timeout && asleep;
      end
   end

   // AXI4-Lite read
   assign rd_idx = idx_of(ARADDR);
   assign rd_hit = idx_mapped(rd_idx);

   always_comb begin
      rd_val = '0;
      unique case (rd_idx)
         pdw_pkg::IDX_CTRL: begin
            rd_val[pdw_pkg::CTRL_EN_BIT]   = timer_enable_q;
            rd_val[pdw_pkg::CTRL_FLAG_BIT] = timeout_flag_q;
            rd_val[pdw_pkg::CTRL_PS_LSB +: pdw_pkg::PS_W] =
               prescale_select_q;
         end
         pdw_pkg::IDX_GIE: begin
            rd_val[pdw_pkg::GIE_BIT] = global_irq_enable_q;
         end
         pdw_pkg::IDX_EIE: begin
            rd_val[pdw_pkg::EIE_WAKE_BIT] = wakeup_irq_enable_q;
         end
         pdw_pkg::IDX_IRQ_STAT: begin
            rd_val[pdw_pkg::IRQ_W-1:0] = irq_stat_q;
         end
         pdw_pkg::IDX_IRQ_EN: begin
            rd_val[pdw_pkg::IRQ_W-1:0] = irq_en_q;
         end
         pdw_pkg::IDX_COUNT: begin
            rd_val[pdw_pkg::CNT_W-1:0] = wakeup_counter_q;
         end
         default: begin
            rd_val = '0;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= '0;
         RRESP   <= pdw_pkg::RESP_OKAY;
      end else if (RVALID) begin
         if (RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
         end
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RDATA   <= {{(pdw_pkg::DATA_W-pdw_pkg::REG_W){1'b0}}, rd_val};
         RRESP   <= rd_hit ? pdw_pkg::RESP_OKAY : pdw_pkg::RESP_SLVERR;
      end else begin
         ARREADY <= 1'b1;
      end
   end

endmodule

// ### tb/pdw_timer_assertions.sv
`timescale 1ns/1ps
module pdw_timer_assertions #(
   parameter int unsigned LSRC_DIV = pdw_pkg::LSRC_DIV
) (
   input wire logic                      CLOCK,
   input wire logic                      SRST,
   input wire logic                      AWVALID,
   input wire logic                      AWREADY,
   input wire logic                      WVALID,
   input wire logic                      WREADY,
   input wire logic [1:0]                BRESP,
   input wire logic                      BVALID,
   input wire logic                      BREADY,
   input wire logic                      ARVALID,
   input wire logic                      ARREADY,
   input wire logic [pdw_pkg::DATA_W-1:0] RDATA,
   input wire logic                      RVALID,
   input wire logic                      RREADY,
   input wire logic                      IDLE_MODE,
   input wire logic                      POWER_DOWN_MODE,
   input wire logic                      IRQ,
   input wire logic                      WAKEUP
);
   wire asleep = IDLE_MODE | POWER_DOWN_MODE;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);

   AST_RESET_QUIET: assert property ($past(SRST) |-> !AWREADY && !BVALID
      && !RVALID && !IRQ && !WAKEUP) else $error("active after reset");
   AST_WRITE_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY
      |=> !AWREADY ##[0:1] BVALID) else $error("write not answered");
   AST_B_STAND: assert property (BVALID && !BREADY |=> BVALID
      && $stable(BRESP)) else $error("write response dropped");
   AST_B_CODE: assert property (BVALID |-> BRESP == pdw_pkg::RESP_OKAY
      || BRESP == pdw_pkg::RESP_SLVERR) else $error("bad write response");
   AST_READ_ANSWER: assert property (ARVALID && ARREADY
      |=> !ARREADY ##[0:1] RVALID) else $error("read not answered");
   AST_R_STAND: assert property (RVALID && !RREADY |=> RVALID
      && $stable(RDATA)) else $error("read response dropped");
   AST_R_DONE: assert property (RVALID && RREADY |=> !RVALID)
      else $error("read response repeated");
   AST_R_UPPER: assert property (RVALID |-> RDATA[31:8] == 24'h0)
      else $error("read upper bits set");
   AST_WAKE_PULSE: assert property ($rose(WAKEUP) |=> !WAKEUP [*8])
      else $error("wake pulse too long");
   AST_WAKE_ASLEEP: assert property (WAKEUP |-> $past(asleep)
      || $past(asleep, 2)) else $error("wake while awake");

   cover property (BVALID && BREADY && BRESP == pdw_pkg::RESP_SLVERR);
   cover property (WAKEUP && POWER_DOWN_MODE);
   cover property ($rose(IRQ));
   cover property (RVALID && RREADY);
endmodule

bind pdw_timer pdw_timer_assertions #(.LSRC_DIV(LSRC_DIV)) u_chk (
   .CLOCK(CLOCK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
   .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
   .RVALID(RVALID), .RREADY(RREADY), .IDLE_MODE(IDLE_MODE),
   .POWER_DOWN_MODE(POWER_DOWN_MODE), .IRQ(IRQ), .WAKEUP(WAKEUP));

// ### tb/powerdown_wakeup_timer_test.sv
`timescale 1ns/1ps
module powerdown_wakeup_timer_test;
   // Short low-speed tick keeps long intervals affordable
   localparam int unsigned DIV = 4;
   logic        CLOCK = 1'b0;
   logic        SRST = 1'b1;
   logic [9:0]  AWADDR = 10'h0, ARADDR = 10'h0;
   logic [2:0]  AWPROT = 3'h0, ARPROT = 3'h0;
   logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic        IDLE_MODE = 0, POWER_DOWN_MODE = 0;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [3:0]  WSTRB = 4'hF;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, WAKEUP;
   logic [1:0]  BRESP, RRESP;
   logic [33:0] exp_r[$];
   logic [1:0]  exp_b[$];
   int          fails = 0, check_count = 0, cyc = 0;
   integer      seed = 32'h8B7E;
   int          ratio [8] = '{1, 4, 8, 32, 64, 256, 512, 1024};
   logic [7:0]  regs [7] = '{8'hAB, 8'hA8, 8'hBD, 8'hB0, 8'hB1, 8'hB2, 8'hB3};

   always #12.5 CLOCK = ~CLOCK;
   always @(posedge CLOCK) cyc <= cyc + 1;

   pdw_timer #(.LSRC_DIV(DIV)) dut (.CLOCK(CLOCK), .SRST(SRST),
      .AWADDR(AWADDR), .AWPROT(AWPROT), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARPROT(ARPROT), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
      .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ),
      .IDLE_MODE(IDLE_MODE), .POWER_DOWN_MODE(POWER_DOWN_MODE),
      .WAKEUP(WAKEUP));

   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic timeout(input string what);
      fails++;
      $display("BAD %s expected response seen none", what);
      report_and_stop();
   endtask

   // Response checks live in the watcher so queue order equals bus order
   always @(posedge CLOCK) begin
      if (BVALID === 1'b1 && BREADY) check("bresp", BRESP, exp_b.pop_front());
      if (RVALID === 1'b1 && RREADY) check("rdata", {RRESP, RDATA},
                                           exp_r.pop_front());
   end

   task automatic acc(input bit w, input logic [7:0] i, input logic [31:0] d,
                      input logic [33:0] e);
      int n;
      bit done;
      n = 0;
      done = 0;
      if (w) begin
         exp_b.push_back(e[33:32]);
         AWADDR <= {i, 2'b00};
         AWPROT <= 3'($random(seed));
         WDATA <= d;
         AWVALID <= 1;
         WVALID <= 1;
         BREADY <= 1;
      end else begin
         exp_r.push_back(e);
         ARADDR <= {i, 2'b00};
         ARPROT <= 3'($random(seed));
         ARVALID <= 1;
         RREADY <= 1;
      end
      do begin
         @(posedge CLOCK);
         n++;
         if (AWVALID && AWREADY === 1'b1) AWVALID <= 0;
         if (WVALID && WREADY === 1'b1) WVALID <= 0;
         if (ARVALID && ARREADY === 1'b1) ARVALID <= 0;
         if (BREADY && BVALID === 1'b1) begin
            BREADY <= 0;
            done = 1;
         end
         if (RREADY && RVALID === 1'b1) begin
            RREADY <= 0;
            done = 1;
         end
      end while (!done && n < 60);
      // One idle edge, so a following call never reassigns a ready at once
      @(posedge CLOCK);
      if (!done) timeout("bus");
   endtask

   task automatic wait_wake(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (WAKEUP !== 1'b1 && n < lim);
      if (WAKEUP !== 1'b1) timeout("wakeup");
   endtask

   initial begin
      int s, t0, m;
      repeat (10) @(posedge CLOCK);
      SRST <= 0;
      @(posedge CLOCK);
      for (s = 0; s < 7; s++) acc(0, regs[s], 0, 0);
      acc(0, 8'h00, 0, {pdw_pkg::RESP_SLVERR, 32'h0});
      acc(1, 8'h00, 32'hFF, {pdw_pkg::RESP_SLVERR, 32'h0});
      // Lane 0 strobe low: write answered but without effect
      WSTRB <= 4'h0;
      acc(1, 8'hAB, 32'hFF, 0);
      WSTRB <= 4'hF;
      acc(0, 8'hAB, 0, 0);
      $display("reset and map done");
      acc(1, 8'hAB, 32'h40, 0);
      repeat (300) @(posedge CLOCK);
      acc(0, 8'hB3, 0, 0);
      acc(0, 8'hAB, 0, 0);
      $display("disabled clear done");
      for (s = 0; s < 5; s++) begin
         IDLE_MODE <= s[0];
         POWER_DOWN_MODE <= !s[0];
         acc(1, 8'hAB, ({$random(seed)} & 32'hFFFFFF00) | (32'h80 | s), 0);
         wait_wake(128 * ratio[s] * DIV + 64);
         t0 = cyc;
         wait_wake(128 * ratio[s] * DIV + 64);
         check("interval", 34'(cyc - t0),
               34'(64 * ratio[s] * DIV));
      end
      acc(0, 8'hAB, 0, 34'hA4);
      acc(0, 8'hB0, 0, 34'h3);
      acc(1, 8'hAB, 32'h84, 0);
      acc(0, 8'hAB, 0, 34'h84);
      // Long ratios: one divided tick seen half a period after its arrival
      for (s = 5; s < 8; s++) begin
         acc(1, 8'hAB, 32'hC0 | s, 0);
         repeat (ratio[s] * DIV * 3 / 2) @(posedge CLOCK);
         acc(0, 8'hB3, 0, 34'h1);
      end
      $display("interval test done");
      IDLE_MODE <= 0;
      POWER_DOWN_MODE <= 0;
      acc(1, 8'hAB, 32'hC0, 0);
      acc(1, 8'hB1, 32'h3, 0);
      m = 0;
      repeat (600) begin
         @(posedge CLOCK);
         if (WAKEUP === 1'b1) m++;
      end
      check("awake wake", 34'(m), 34'h0);
      acc(0, 8'hB0, 0, 34'h1);
      acc(0, 8'hAB, 0, 34'hA0);
      $display("awake test done");
      acc(1, 8'hAB, 32'h0, 0);
      for (m = 0; m < 8; m++) begin
         acc(1, 8'hA8, ({$random(seed)} & 32'hFFFFFF00) | (m[2] << 7), 0);
         acc(1, 8'hBD, m[1] << 1, 0);
         acc(1, 8'hB2, m[0], 0);
         repeat (3) @(posedge CLOCK);
         check("irq gate", 34'(IRQ), 34'(m == 7));
      end
      acc(0, 8'hA8, 0, 34'h80);
      acc(1, 8'hB1, 32'h1, 0);
      repeat (3) @(posedge CLOCK);
      check("irq clear", 34'(IRQ), 34'h0);
      acc(0, 8'hB0, 0, 0);
      $display("interrupt test done");
      report_and_stop();
   end
endmodule
